//--- rtl/pjw_consts.svh
// constants for the jitter write control block
`ifndef PJW_CONSTS_SVH
`define PJW_CONSTS_SVH
// register byte offsets
`define PJW_A_CTRL 8'h00
`define PJW_A_DESIRED 8'h04
`define PJW_A_MAX_USED 8'h08
`define PJW_A_MAX_PAY 8'h0C
`define PJW_A_UND_LEAD 8'h10
`define PJW_A_OVR_LEAD 8'h14
`define PJW_A_INIT_LEAD 8'h18
`define PJW_A_SLIP 8'h1C
`define PJW_A_MIN_DELTA 8'h20
`define PJW_A_MAX_DELTA 8'h24
`define PJW_A_LAST_LOCAL 8'h28
`define PJW_A_LAST_REMOTE 8'h2C
// control register bit positions
`define PJW_B_OVR_INH 0
`define PJW_B_EXT 1
`define PJW_B_UND_INH 2
`define PJW_B_ALWAYS 3
`define PJW_B_ONCE 4
`define PJW_B_LOSS 5
`define PJW_B_MARKER 6
`define PJW_B_MSLIP_LO 8
`define PJW_B_MSLIP_HI 10
`define PJW_B_INIT_DONE 12
// smallest silence gap in frames, at code zero
`define PJW_GAP_BASE 12'h010
// frame period of the tdm bus in us, and the 2 ms smallest gap that code zero stands for
`define PJW_FRAME_US 125
`define PJW_GAP_MIN_MS 2
`endif

//--- rtl/pjw_gap_det.sv
// silence gap detector for reset on loss
`timescale 1ns/1ns
`include "pjw_consts.svh"
module pjw_gap_det (
  // packet history
  input wire logic [31:0] remote_ts_in,
  input wire logic [31:0] expect_ts_in,
  input wire logic [2:0] code_in,
  // result
  output logic [31:0] lost_out,
  output logic big_gap_out
);
  logic [31:0] thresh;
  // frames missing between the last packet's end and this one
  assign lost_out = remote_ts_in - expect_ts_in;
  // 16 frames doubling per code step
  assign thresh = {20'h00000, `PJW_GAP_BASE} << code_in; // see R22
  // a late-wrapped negative gap is not a loss
  assign big_gap_out = !lost_out[31] && lost_out >= thresh; // see R12
endmodule

//--- rtl/pjw_minmax.sv
// running minimum and maximum of the remote-local delta
`timescale 1ns/1ns
module pjw_minmax (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // update side
  input wire logic restart_in,
  input wire logic update_in,
  input wire logic signed [31:0] delta_in,
  // results
  output logic signed [31:0] min_out,
  output logic signed [31:0] max_out
);
  // restart takes the first delta as both extremes
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      min_out <= 32'sh0;
      max_out <= 32'sh0;
    end else if (update_in) begin
      if (restart_in || delta_in < min_out) begin
        min_out <= delta_in; // see R9
      end
      if (restart_in || delta_in > max_out) begin
        max_out <= delta_in; // see R9
      end
    end
  end

  property p_min_le_max;
    @(posedge clk_sys_in) disable iff (reset_in)
      $past(update_in) && !$past(reset_in) |-> min_out <= max_out;
  endproperty
  a_min_le_max: assert property (p_min_le_max) // see R9
    else $error("min delta above max delta");
endmodule

//--- rtl/pjw_monitor.sv
// packet delay variation monitor placing packets in the playout buffer
// Contract
// R1: write position follows packet remote timestamp
// R2: payload size variation absorbed, not slipped
// R3: usable window is max used minus payload
// R4: negative lead gives underrun, underrun lead
// R5: lead beyond max used gives overrun
// R6: first packet placed at init lead
// R7: each slip updates slip offset
// R8: software zeroes desired delta first
// R9: keep min and max delta seen
// R10: reset once clears offset next packet
// R11: reset on marker waits for marker
// R12: reset on loss after long gap
// R13: always mode writes desired delta exactly
// R14: always mode may corrupt on underrun
// R15: overrun inhibit keeps offset, reports only
// R16: underrun inhibit keeps offset, reports only
// R17: software corrects offset when inhibited
// R18: software writes extended bit zero
// R19: store local timestamp of last packet
// R20: software may fold offset into delta
// R21: many channels share one delay structure
// R22: min slip code 16 to 2048 frames
// R23: offset signed, overrun adds, underrun subtracts
// R24: delta is remote minus local
// R25: hardware clears reset request after use
// R26: write positions wrap modulo buffer size
`timescale 1ns/1ns
`include "pjw_consts.svh"
module pjw_monitor #(
  parameter int AW = 12 // playout buffer holds 2**AW samples
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // packet from the disassembly datapath
  input wire logic pkt_valid_in,
  input wire logic [9:0] pkt_chan_in,
  input wire logic [31:0] pkt_remote_ts_in,
  input wire logic [11:0] pkt_samples_in,
  input wire logic pkt_marker_in,
  // local bus timestamp, its low bits are the tdm read pointer
  input wire logic [31:0] local_ts_in,
  // placement result
  output logic wr_valid_out,
  output logic [9:0] wr_chan_out,
  output logic [AW-1:0] wr_ptr_out,
  output pjw_pkg::pjw_act_t wr_act_out,
  output logic underrun_out,
  output logic overrun_out,
  output logic slip_reset_done_out
);
  import pjw_pkg::*;

  // control bits, software set, some hardware cleared
  logic overrun_slip_inhibit_reg;
  logic underrun_slip_inhibit_reg;
  logic extended_mode_bit_reg; // stored only
  logic always_reset_reg;
  logic slip_reset_once_reg;
  logic slip_reset_on_loss_reg;
  logic slip_reset_on_marker_reg;
  logic [2:0] min_slip_reg;
  logic init_done_reg; // first packet seen by the structure
  // delay structure words
  logic signed [31:0] desired_reg;
  logic [15:0] max_used_reg;
  logic [11:0] max_pay_reg;
  logic [15:0] und_lead_reg;
  logic [15:0] ovr_lead_reg;
  logic [15:0] init_lead_reg;
  logic signed [31:0] slip_reg;
  logic [31:0] last_local_reg;
  logic [31:0] last_remote_reg;
  logic [31:0] expect_ts_reg; // remote ts where next packet should start
  // datapath
  logic signed [31:0] delta;
  logic signed [31:0] slip_use;
  logic signed [31:0] lead;
  logic signed [31:0] new_lead;
  logic signed [31:0] slip_next;
  logic big_gap;
  logic under_det;
  logic over_det;
  logic reset_req;
  logic do_once;
  logic do_loss;
  logic do_marker;
  logic wr_ctrl;
  logic wr_slip;
  logic signed [31:0] min_delta;
  logic signed [31:0] max_delta;
  pjw_act_t act;

  // bus strobes, each access acked in the cycle after its strobe
  assign wr_ctrl = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out
                   && wb_adr_in == `PJW_A_CTRL;
  assign wr_slip = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out
                   && wb_adr_in == `PJW_A_SLIP;

  // delta is remote minus local
  assign delta = $signed(pkt_remote_ts_in - local_ts_in); // see R24

  // reset requests that fire on this packet
  assign do_once = slip_reset_once_reg; // see R10
  assign do_marker = slip_reset_on_marker_reg && pkt_marker_in; // see R11
  assign do_loss = slip_reset_on_loss_reg && init_done_reg && big_gap; // see R12
  assign reset_req = do_once || do_marker || do_loss;

  // always mode and a reset both play at exactly the desired delta
  assign slip_use = (always_reset_reg || reset_req) ? 32'sh0 : slip_reg; // see R13

  // lead of the desired write position over the read pointer
  assign lead = delta - desired_reg - slip_use; // see R1

  // underrun when the lead would go negative
  assign under_det = lead < 32'sh0; // see R4
  // overrun counted with the largest payload, so size changes do not slip
  assign over_det = lead + $signed({20'h00000, max_pay_reg}) - 32'sh1
                    > $signed({16'h0000, max_used_reg}); // see R2 R3 R5

  // choose what happens to this packet
  always_comb begin
    act = PJW_NORMAL;
    if (!init_done_reg) begin
      act = PJW_INIT; // see R6
    end else if (reset_req || always_reset_reg) begin
      act = PJW_RESET; // see R13 R14
    end else if (under_det) begin
      act = PJW_UNDER;
    end else if (over_det) begin
      act = PJW_OVER;
    end
  end

  // lead actually used and the offset that follows
  always_comb begin
    new_lead = lead;
    slip_next = slip_reg;
    unique case (act)
      PJW_NORMAL: begin
        new_lead = lead;
      end
      PJW_INIT: begin
        new_lead = $signed({16'h0000, init_lead_reg}); // see R6
        slip_next = slip_reg + lead - new_lead;
      end
      PJW_RESET: begin
        // always mode never touches the offset, one-shot resets zero it
        if (!always_reset_reg) begin
          slip_next = 32'sh0; // see R10 R11 R12
        end
      end
      PJW_UNDER: begin
        // inhibited underrun keeps position and offset, report only
        if (!underrun_slip_inhibit_reg) begin
          new_lead = $signed({16'h0000, und_lead_reg}); // see R4 R16
          slip_next = slip_reg + lead - new_lead; // see R7 R23
        end
      end
      PJW_OVER: begin
        if (!overrun_slip_inhibit_reg) begin
          new_lead = $signed({16'h0000, ovr_lead_reg}); // see R5 R15
          slip_next = slip_reg + lead - new_lead; // see R7 R23
        end
      end
    endcase
  end

  // loss detector against the expected next timestamp
  pjw_gap_det u_gap (
    .remote_ts_in(pkt_remote_ts_in),
    .expect_ts_in(expect_ts_reg),
    .code_in(min_slip_reg),
    .lost_out(),
    .big_gap_out(big_gap)
  );

  // min and max delta, restarted on the first packet
  pjw_minmax u_minmax (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .restart_in(!init_done_reg),
    .update_in(pkt_valid_in),
    .delta_in(delta),
    .min_out(min_delta),
    .max_out(max_delta)
  );

  // slip offset, one shared by every channel of this structure
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      slip_reg <= 32'sh0;
    end else if (wr_slip) begin
      // software correction wins over a same-cycle slip
      slip_reg <= $signed(wb_dat_in); // see R17 R20
    end else if (pkt_valid_in) begin
      slip_reg <= slip_next; // see R21
    end
  end

  // control register, hardware clears requests and sets init
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      overrun_slip_inhibit_reg <= 1'b0;
      underrun_slip_inhibit_reg <= 1'b0;
      extended_mode_bit_reg <= 1'b0;
      always_reset_reg <= 1'b0;
      slip_reset_once_reg <= 1'b0;
      slip_reset_on_loss_reg <= 1'b0;
      slip_reset_on_marker_reg <= 1'b0;
      min_slip_reg <= 3'h0;
      init_done_reg <= 1'b0;
    end else begin
      // hardware clear first, so a software set in the same cycle wins
      if (pkt_valid_in && init_done_reg) begin
        if (do_once || do_marker || do_loss) begin
          slip_reset_once_reg <= 1'b0; // see R25
          slip_reset_on_marker_reg <= 1'b0; // see R25
          slip_reset_on_loss_reg <= 1'b0; // see R25
        end
      end
      if (wr_ctrl && wb_sel_in[0]) begin
        overrun_slip_inhibit_reg <= wb_dat_in[`PJW_B_OVR_INH];
        extended_mode_bit_reg <= wb_dat_in[`PJW_B_EXT]; // see R18
        underrun_slip_inhibit_reg <= wb_dat_in[`PJW_B_UND_INH];
        always_reset_reg <= wb_dat_in[`PJW_B_ALWAYS];
        slip_reset_once_reg <= wb_dat_in[`PJW_B_ONCE];
        slip_reset_on_loss_reg <= wb_dat_in[`PJW_B_LOSS];
        slip_reset_on_marker_reg <= wb_dat_in[`PJW_B_MARKER];
      end
      if (wr_ctrl && wb_sel_in[1]) begin
        min_slip_reg <= wb_dat_in[`PJW_B_MSLIP_HI:`PJW_B_MSLIP_LO];
        // writing zero re-arms the first packet placement
        if (!wb_dat_in[`PJW_B_INIT_DONE]) begin
          init_done_reg <= 1'b0;
        end
      end
      // a packet in the same cycle as a re-arm wins, so its set is not lost
      if (pkt_valid_in) begin
        init_done_reg <= 1'b1;
      end
    end
  end

  // plain software words
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      desired_reg <= 32'sh0; // see R8
      max_used_reg <= 16'h0000;
      max_pay_reg <= 12'h000;
      und_lead_reg <= 16'h0000;
      ovr_lead_reg <= 16'h0000;
      init_lead_reg <= 16'h0000;
    end else if (wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out) begin
      unique case (wb_adr_in)
        `PJW_A_DESIRED: desired_reg <= $signed(wb_dat_in);
        `PJW_A_MAX_USED: max_used_reg <= wb_dat_in[15:0];
        `PJW_A_MAX_PAY: max_pay_reg <= wb_dat_in[11:0];
        `PJW_A_UND_LEAD: und_lead_reg <= wb_dat_in[15:0];
        `PJW_A_OVR_LEAD: ovr_lead_reg <= wb_dat_in[15:0];
        `PJW_A_INIT_LEAD: init_lead_reg <= wb_dat_in[15:0];
        default: begin
        end
      endcase
    end
  end

  // history of the last packet
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      last_local_reg <= 32'h0;
      last_remote_reg <= 32'h0;
      expect_ts_reg <= 32'h0;
    end else if (pkt_valid_in) begin
      last_local_reg <= local_ts_in; // see R19
      last_remote_reg <= pkt_remote_ts_in;
      expect_ts_reg <= pkt_remote_ts_in + {20'h00000, pkt_samples_in};
    end
  end

  // placement output, write pointer wraps with the buffer
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      wr_valid_out <= 1'b0;
      wr_chan_out <= 10'h000;
      wr_ptr_out <= '0;
      wr_act_out <= PJW_NORMAL;
      underrun_out <= 1'b0;
      overrun_out <= 1'b0;
      slip_reset_done_out <= 1'b0;
    end else begin
      wr_valid_out <= pkt_valid_in;
      wr_chan_out <= pkt_chan_in;
      wr_ptr_out <= AW'(local_ts_in + new_lead); // see R26
      wr_act_out <= act;
      underrun_out <= pkt_valid_in && init_done_reg && under_det;
      overrun_out <= pkt_valid_in && init_done_reg && !under_det && over_det;
      slip_reset_done_out <= pkt_valid_in && act == PJW_RESET && !always_reset_reg;
    end
  end

  // bus read mux and ack, unmapped reads return zero
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0;
    end else begin
      wb_ack_out <= wb_cyc_in && wb_stb_in && !wb_ack_out;
      unique case (wb_adr_in)
        `PJW_A_CTRL: begin
          wb_dat_out <= 32'h0;
          wb_dat_out[`PJW_B_OVR_INH] <= overrun_slip_inhibit_reg;
          wb_dat_out[`PJW_B_EXT] <= extended_mode_bit_reg;
          wb_dat_out[`PJW_B_UND_INH] <= underrun_slip_inhibit_reg;
          wb_dat_out[`PJW_B_ALWAYS] <= always_reset_reg;
          wb_dat_out[`PJW_B_ONCE] <= slip_reset_once_reg;
          wb_dat_out[`PJW_B_LOSS] <= slip_reset_on_loss_reg;
          wb_dat_out[`PJW_B_MARKER] <= slip_reset_on_marker_reg;
          wb_dat_out[`PJW_B_MSLIP_HI:`PJW_B_MSLIP_LO] <= min_slip_reg;
          wb_dat_out[`PJW_B_INIT_DONE] <= init_done_reg;
        end
        `PJW_A_DESIRED: wb_dat_out <= desired_reg;
        `PJW_A_MAX_USED: wb_dat_out <= {16'h0000, max_used_reg};
        `PJW_A_MAX_PAY: wb_dat_out <= {20'h00000, max_pay_reg};
        `PJW_A_UND_LEAD: wb_dat_out <= {16'h0000, und_lead_reg};
        `PJW_A_OVR_LEAD: wb_dat_out <= {16'h0000, ovr_lead_reg};
        `PJW_A_INIT_LEAD: wb_dat_out <= {16'h0000, init_lead_reg};
        `PJW_A_SLIP: wb_dat_out <= slip_reg;
        `PJW_A_MIN_DELTA: wb_dat_out <= min_delta;
        `PJW_A_MAX_DELTA: wb_dat_out <= max_delta;
        `PJW_A_LAST_LOCAL: wb_dat_out <= last_local_reg;
        `PJW_A_LAST_REMOTE: wb_dat_out <= last_remote_reg;
        default: wb_dat_out <= 32'h0;
      endcase
    end
  end

  // checks
  property p_under_ptr;
    @(posedge clk_sys_in) disable iff (reset_in)
      pkt_valid_in && act == PJW_UNDER && !underrun_slip_inhibit_reg
      |=> wr_ptr_out == AW'($past(local_ts_in) + {16'h0000, $past(und_lead_reg)});
  endproperty
  a_under_ptr: assert property (p_under_ptr) // see R4
    else $error("underrun pointer not at underrun lead");

  property p_over_ptr;
    @(posedge clk_sys_in) disable iff (reset_in)
      pkt_valid_in && act == PJW_OVER && !overrun_slip_inhibit_reg
      |=> wr_ptr_out == AW'($past(local_ts_in) + {16'h0000, $past(ovr_lead_reg)});
  endproperty
  a_over_ptr: assert property (p_over_ptr) // see R5
    else $error("overrun pointer not at overrun lead");

  property p_under_sub;
    @(posedge clk_sys_in) disable iff (reset_in)
      pkt_valid_in && !wr_slip && act == PJW_UNDER && !underrun_slip_inhibit_reg
      |=> slip_reg < $past(slip_reg);
  endproperty
  a_under_sub: assert property (p_under_sub) // see R23
    else $error("underrun did not lower slip offset");

  property p_inhibit;
    @(posedge clk_sys_in) disable iff (reset_in)
      pkt_valid_in && !wr_slip && ((act == PJW_OVER && overrun_slip_inhibit_reg)
      || (act == PJW_UNDER && underrun_slip_inhibit_reg)) |=> $stable(slip_reg);
  endproperty
  a_inhibit: assert property (p_inhibit) // see R15 R16
    else $error("inhibited slip changed offset");

  property p_always;
    @(posedge clk_sys_in) disable iff (reset_in)
      always_reset_reg && init_done_reg && !wr_slip ##1 always_reset_reg
      |-> $stable(slip_reg);
  endproperty
  a_always: assert property (p_always) // see R13
    else $error("slip offset moved in always mode");

  property p_once_clear;
    @(posedge clk_sys_in) disable iff (reset_in)
      pkt_valid_in && init_done_reg && slip_reset_once_reg && !wr_ctrl && !wr_slip
      |=> !slip_reset_once_reg && slip_reg == 32'sh0;
  endproperty
  a_once_clear: assert property (p_once_clear) // see R10 R25
    else $error("reset once not applied");

  property p_marker_wait;
    @(posedge clk_sys_in) disable iff (reset_in)
      slip_reset_on_marker_reg && !pkt_marker_in && !do_once && !do_loss && !wr_ctrl
      |=> slip_reset_on_marker_reg;
  endproperty
  a_marker_wait: assert property (p_marker_wait) // see R11
    else $error("marker reset fired without marker");

  property p_last_local;
    @(posedge clk_sys_in) disable iff (reset_in)
      pkt_valid_in |=> last_local_reg == $past(local_ts_in);
  endproperty
  a_last_local: assert property (p_last_local) // see R19
    else $error("last local timestamp not stored");

  property p_ack_once;
    @(posedge clk_sys_in) disable iff (reset_in)
      wb_ack_out |=> !wb_ack_out;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack held two cycles");

  c_under: cover property (@(posedge clk_sys_in) pkt_valid_in && act == PJW_UNDER);
  c_over: cover property (@(posedge clk_sys_in) pkt_valid_in && act == PJW_OVER);
  c_loss: cover property (@(posedge clk_sys_in) pkt_valid_in && do_loss);
endmodule

//--- rtl/pjw_pkg.sv
// types for the jitter write control block
package pjw_pkg;
  // what the monitor did with one packet
  typedef enum logic [2:0] {
    PJW_NORMAL,
    PJW_INIT,
    PJW_RESET,
    PJW_UNDER,
    PJW_OVER
  } pjw_act_t;
endpackage

//--- tb/pjw_pkt_src.sv
// packet source standing in for the disassembly datapath
`timescale 1ns/1ns
module pjw_pkt_src (
  // clock
  input wire logic clk_sys_in,
  // packet towards the monitor
  output logic pkt_valid_out,
  output logic [9:0] pkt_chan_out,
  output logic [31:0] pkt_remote_ts_out,
  output logic [11:0] pkt_samples_out,
  output logic pkt_marker_out,
  output logic [31:0] local_ts_out
);
  // payload already turned into a sample count
  localparam logic [11:0] SAMPLES = 12'h004;
  // idle until the first packet
  initial begin
    pkt_valid_out = 1'b0;
    pkt_chan_out = 10'h000;
    pkt_remote_ts_out = 32'h0;
    pkt_samples_out = 12'h000;
    pkt_marker_out = 1'b0;
    local_ts_out = 32'h0;
  end
  // one-cycle pulse; fields inverted afterwards so stale values are never reused
  task automatic send(input logic [9:0] chan, input logic [31:0] lt, input logic [31:0] rt,
                      input logic mk);
    @(posedge clk_sys_in);
    pkt_valid_out <= 1'b1;
    pkt_chan_out <= chan;
    pkt_remote_ts_out <= rt;
    pkt_samples_out <= SAMPLES;
    pkt_marker_out <= mk;
    local_ts_out <= lt;
    @(posedge clk_sys_in);
    pkt_valid_out <= 1'b0;
    pkt_chan_out <= ~chan;
    pkt_remote_ts_out <= ~rt;
    pkt_samples_out <= ~SAMPLES;
    pkt_marker_out <= ~mk;
    local_ts_out <= ~lt;
  endtask
endmodule

//--- tb/tb_pjw_monitor.sv
// self-checking bench for the jitter write control monitor
`timescale 1ns/1ns
`include "pjw_consts.svh"
module tb_pjw_monitor;
  import pjw_pkg::*;
  logic clk_sys_in, reset_in; // clock and sync reset
  logic wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out; // bus control
  logic [7:0] wb_adr_in;
  logic [3:0] wb_sel_in;
  logic [31:0] wb_dat_in, wb_dat_out, rd; // bus data, last read
  logic pkt_valid_in, pkt_marker_in, wr_valid_out, underrun_out, overrun_out;
  logic slip_reset_done_out, rst_seen; // reset pulse, as last seen
  logic [9:0] pkt_chan_in, wr_chan_out, chan;
  logic [31:0] pkt_remote_ts_in, local_ts_in;
  logic [11:0] pkt_samples_in, wr_ptr_out;
  pjw_act_t wr_act_out;
  int fails, checked;
  // partner feeding packets
  pjw_pkt_src u_src (.clk_sys_in(clk_sys_in), .pkt_valid_out(pkt_valid_in),
    .pkt_chan_out(pkt_chan_in), .pkt_remote_ts_out(pkt_remote_ts_in),
    .pkt_samples_out(pkt_samples_in), .pkt_marker_out(pkt_marker_in),
    .local_ts_out(local_ts_in));
  // design under test
  pjw_monitor #(.AW(12)) u_dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .pkt_valid_in(pkt_valid_in),
    .pkt_chan_in(pkt_chan_in), .pkt_remote_ts_in(pkt_remote_ts_in),
    .pkt_samples_in(pkt_samples_in), .pkt_marker_in(pkt_marker_in),
    .local_ts_in(local_ts_in), .wr_valid_out(wr_valid_out), .wr_chan_out(wr_chan_out),
    .wr_ptr_out(wr_ptr_out), .wr_act_out(wr_act_out), .underrun_out(underrun_out),
    .overrun_out(overrun_out), .slip_reset_done_out(slip_reset_done_out));
  // 25 MHz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // closing: counts then verdict
  task automatic give_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // one classic cycle, released at the edge that samples ack
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    input logic [3:0] sel);
    @(posedge clk_sys_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= adr;
    wb_dat_in <= dat;
    wb_sel_in <= sel;
    // ack and read data taken at the edge itself; only the watchdog ends a hang
    do begin
      @(posedge clk_sys_in);
    end while (wb_ack_out !== 1'b1);
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_we_in <= 1'b0;
  endtask
  // read and compare
  task automatic rchk(input string what, input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0, 4'hF);
    check(what, rd, exp);
  endtask
  // one packet; ptr, action and slip flags checked in the answer cycle
  task automatic pkt(input logic [31:0] lt, input logic [31:0] rt, input logic mk,
                     input pjw_act_t act, input logic [11:0] ptr, input logic [1:0] uo);
    chan = chan + 10'h0F1;
    u_src.send(chan, lt, rt, mk);
    #1;
    rst_seen = slip_reset_done_out;
    check("valid", {31'h0, wr_valid_out}, 32'h1);
    check("chan", {22'h0, wr_chan_out}, {22'h0, chan});
    check("act", {29'h0, wr_act_out}, {29'h0, act});
    check("ptr", {20'h0, wr_ptr_out}, {20'h0, ptr});
    check("flags", {30'h0, underrun_out, overrun_out}, {30'h0, uo});
  endtask
  // hang guard
  initial begin
    repeat (4000) @(posedge clk_sys_in);
    fails++;
    give_verdict();
  end
  // main sequence
  initial begin
    fails = 0;
    checked = 0;
    chan = 10'h000;
    rd = 32'h0;
    reset_in = 1'b1;
    wb_cyc_in = 1'b0;
    wb_stb_in = 1'b0;
    wb_we_in = 1'b0;
    wb_adr_in = 8'h00;
    wb_sel_in = 4'h0;
    wb_dat_in = 32'h0;
    repeat (20) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    rchk("ctrl", `PJW_A_CTRL, 32'h0);
    wb(1'b1, 8'h30, 32'hFFFFFFFF, 4'hF);
    rchk("unmapped", 8'h30, 32'h0);
    wb(1'b1, `PJW_A_DESIRED, 32'h0, 4'hF);
    wb(1'b1, `PJW_A_CTRL, 32'h0, 4'hF);
    wb(1'b1, `PJW_A_MAX_USED, 32'h64, 4'hF);
    wb(1'b1, `PJW_A_MAX_PAY, 32'hA, 4'hF);
    wb(1'b1, `PJW_A_UND_LEAD, 32'h8, 4'hF);
    wb(1'b1, `PJW_A_OVR_LEAD, 32'h50, 4'hF);
    wb(1'b1, `PJW_A_INIT_LEAD, 32'h14, 4'hF);
    $display("test setup done");
    pkt(32'hFFA, 32'h1018, 1'b0, PJW_INIT, 12'h00E, 2'b00);
    rchk("slip", `PJW_A_SLIP, 32'hA);
    rchk("init", `PJW_A_CTRL, 32'h1000);
    pkt(32'h44C, 32'h4B1, 1'b0, PJW_NORMAL, 12'h4A7, 2'b00);
    check("no reset", {31'h0, rst_seen}, 32'h0);
    pkt(32'h4B0, 32'h4B5, 1'b0, PJW_UNDER, 12'h4B8, 2'b10);
    pkt(32'h514, 32'h56D, 1'b0, PJW_OVER, 12'h564, 2'b01);
    rchk("slip", `PJW_A_SLIP, 32'h9);
    $display("test slips done");
    wb(1'b1, `PJW_A_CTRL, 32'h04, 4'h1);
    pkt(32'h578, 32'h57D, 1'b0, PJW_UNDER, 12'h574, 2'b10);
    wb(1'b1, `PJW_A_CTRL, 32'h01, 4'h1);
    pkt(32'h5DC, 32'h6A4, 1'b0, PJW_OVER, 12'h69B, 2'b01);
    rchk("slip", `PJW_A_SLIP, 32'h9);
    $display("test inhibit done");
    wb(1'b1, `PJW_A_CTRL, 32'h10, 4'h1);
    pkt(32'h640, 32'h64A, 1'b0, PJW_RESET, 12'h64A, 2'b00);
    check("reset once", {31'h0, rst_seen}, 32'h1);
    rchk("slip", `PJW_A_SLIP, 32'h0);
    rchk("once clr", `PJW_A_CTRL, 32'h1000);
    wb(1'b1, `PJW_A_SLIP, 32'h5, 4'hF);
    wb(1'b1, `PJW_A_CTRL, 32'h40, 4'h1);
    pkt(32'h6A4, 32'h6B8, 1'b0, PJW_NORMAL, 12'h6B3, 2'b00);
    pkt(32'h708, 32'h71C, 1'b1, PJW_RESET, 12'h71C, 2'b00);
    check("reset mark", {31'h0, rst_seen}, 32'h1);
    rchk("mark clr", `PJW_A_CTRL, 32'h1000);
    $display("test marker done");
    wb(1'b1, `PJW_A_SLIP, 32'h5, 4'hF);
    wb(1'b1, `PJW_A_CTRL, 32'h20, 4'h1);
    pkt(32'h712, 32'h72F, 1'b0, PJW_NORMAL, 12'h72A, 2'b00);
    pkt(32'h726, 32'h743, 1'b0, PJW_RESET, 12'h743, 2'b00);
    check("reset loss", {31'h0, rst_seen}, 32'h1);
    rchk("slip", `PJW_A_SLIP, 32'h0);
    wb(1'b1, `PJW_A_SLIP, 32'h3, 4'hF);
    wb(1'b1, `PJW_A_CTRL, 32'h1120, 4'h3);
    pkt(32'h752, 32'h766, 1'b0, PJW_NORMAL, 12'h763, 2'b00);
    pkt(32'h776, 32'h78A, 1'b0, PJW_RESET, 12'h78A, 2'b00);
    check("reset code", {31'h0, rst_seen}, 32'h1);
    rchk("code", `PJW_A_CTRL, 32'h1100);
    $display("test loss done");
    wb(1'b1, `PJW_A_SLIP, 32'h7, 4'hF);
    wb(1'b1, `PJW_A_CTRL, 32'h08, 4'h1);
    pkt(32'h76C, 32'h834, 1'b0, PJW_RESET, 12'h834, 2'b01);
    pkt(32'h7D0, 32'h7C6, 1'b0, PJW_RESET, 12'h7C6, 2'b10);
    rchk("slip", `PJW_A_SLIP, 32'h7);
    rchk("min", `PJW_A_MIN_DELTA, 32'hFFFFFFF6);
    rchk("max", `PJW_A_MAX_DELTA, 32'hC8);
    rchk("local", `PJW_A_LAST_LOCAL, 32'h7D0);
    rchk("remote", `PJW_A_LAST_REMOTE, 32'h7C6);
    $display("test always done");
    give_verdict();
  end
endmodule
